// file: logic/scs_supervisor.sv
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - supervise only after startup completes, every cycle
// - overrun without handler enters stop
// - overrun with handler dispatches handler
// - retrigger clears timer only from program cycle
// - second overrun without retrigger stops immediately
// - periodic communication slice sized by load percent
// - minimum cycle enforced within tolerance
// - spare time spent on diagnostics and communication
// - minimum overrun raises no reaction
// - max limit 1..6000 ms, default 150
// - minimum disabled by default, 1..max ms
// - no minimum means next cycle starts immediately
// - handler receives code for maximum cycle exceeded
module scs_supervisor #(
	parameter int TICK_CYC = scs_pkg::TICK_CYC,
	parameter int COMM_PERIOD_MS = scs_pkg::COMM_PERIOD_MS
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// sequencer
	input wire scs_pkg::scs_seq_in_t seq_i,
	output scs_pkg::scs_seq_out_t seq_o,
	output logic [7:0] time_error_code,
	// interrupt
	output logic irq
);
	scs_pkg::scs_state_t state_r;
	logic [1:0] ctrl_r;
	logic [12:0] max_ms_r, min_ms_r;
	logic [7:0] comm_pct_r;
	logic [12:0] cyc_ms_r;
	logic [31:0] tick_r;
	logic tick;
	logic [12:0] period_ms_r, slice_ms_r;
	logic slice_r;
	logic overrun_armed_r;
	logic [scs_pkg::IRQ_W-1:0] ist_r, imask_r, ev;
	logic over;
	logic aw_ok_r, w_ok_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [12:0] slice_len;

	assign tick = (tick_r == 32'(TICK_CYC - 1));
	assign over = (cyc_ms_r >= max_ms_r) && tick;
	assign slice_len = 13'((32'(COMM_PERIOD_MS) * 32'(comm_pct_r)) / 32'd100);

	// millisecond prescaler runs in every state except startup, stop included
	always_ff @(posedge aclk) begin
		if (!aresetn || state_r == scs_pkg::SCS_STARTUP)
			tick_r <= '0;
		else if (tick)
			tick_r <= '0;
		else
			tick_r <= tick_r + 32'd1;
	end

	// cycle-duration timer
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cyc_ms_r <= '0;
		else if (seq_o.cycle_start)
			cyc_ms_r <= '0;
		else if (seq_i.retrigger && !seq_i.in_handler &&
				state_r == scs_pkg::SCS_WORK)
			cyc_ms_r <= '0;
		// an overrun restarts the count, so a second needs a full limit
		else if (over)
			cyc_ms_r <= '0;
		else if (tick && state_r != scs_pkg::SCS_STOP &&
				cyc_ms_r != 13'h1FFF)
			cyc_ms_r <= cyc_ms_r + 13'h0001;
	end

	// communication slice: fixed period, length scaled by load percent
	always_ff @(posedge aclk) begin
		if (!aresetn || state_r == scs_pkg::SCS_STARTUP) begin
			period_ms_r <= '0;
			slice_ms_r <= '0;
			slice_r <= 1'b0;
		end else if (tick) begin
			if (period_ms_r == 13'(COMM_PERIOD_MS - 1)) begin
				period_ms_r <= '0;
				slice_ms_r <= slice_len;
				slice_r <= (slice_len != 13'h0000);
			end else begin
				period_ms_r <= period_ms_r + 13'h0001;
				if (slice_ms_r > 13'h0001)
					slice_ms_r <= slice_ms_r - 13'h0001;
				else begin
					slice_ms_r <= '0;
					slice_r <= 1'b0;
				end
			end
		end
	end

	// sequencing and overrun reaction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= scs_pkg::SCS_STARTUP;
			overrun_armed_r <= 1'b0;
			seq_o <= '0;
			time_error_code <= '0;
		end else begin
			seq_o.cycle_start <= 1'b0;
			seq_o.handler_go <= 1'b0;
			seq_o.pad_active <= 1'b0;
			if (seq_i.retrigger && !seq_i.in_handler)
				overrun_armed_r <= 1'b0;
			case (state_r)
			scs_pkg::SCS_STARTUP: begin
				if (seq_i.startup_done) begin
					state_r <= scs_pkg::SCS_WORK;
					seq_o.cycle_start <= 1'b1;
					seq_o.run <= 1'b1;
				end
			end
			scs_pkg::SCS_WORK, scs_pkg::SCS_HANDLER, scs_pkg::SCS_PAD: begin
				if (over && overrun_armed_r) begin
					state_r <= scs_pkg::SCS_STOP;
					seq_o.run <= 1'b0;
					seq_o.stopped <= 1'b1;
				end else if (over && state_r != scs_pkg::SCS_PAD &&
						!ctrl_r[scs_pkg::CTRL_HANDLER_EN]) begin
					state_r <= scs_pkg::SCS_STOP;
					seq_o.run <= 1'b0;
					seq_o.stopped <= 1'b1;
				end else if (over && state_r != scs_pkg::SCS_PAD) begin
					overrun_armed_r <= 1'b1;
					state_r <= scs_pkg::SCS_HANDLER;
					seq_o.handler_go <= 1'b1;
					time_error_code <= scs_pkg::TERR_CODE_MAXCYC;
				end else if (state_r == scs_pkg::SCS_HANDLER) begin
					if (seq_i.handler_done)
						state_r <= scs_pkg::SCS_WORK;
				end else if (state_r == scs_pkg::SCS_PAD) begin
					if (cyc_ms_r >= min_ms_r) begin
						state_r <= scs_pkg::SCS_WORK;
						seq_o.cycle_start <= 1'b1;
						overrun_armed_r <= 1'b0;
					end else begin
						seq_o.pad_active <= 1'b1;
					end
				end else if (seq_i.cycle_end) begin
					if (ctrl_r[scs_pkg::CTRL_MINCYC_EN] &&
							cyc_ms_r < min_ms_r) begin
						state_r <= scs_pkg::SCS_PAD;
						seq_o.pad_active <= 1'b1;
					end else begin
						// past the minimum: no reaction at all
						seq_o.cycle_start <= 1'b1;
						overrun_armed_r <= 1'b0;
					end
				end
			end
			scs_pkg::SCS_STOP: begin
				seq_o.run <= 1'b0;
				seq_o.stopped <= 1'b1;
			end
			default: state_r <= scs_pkg::SCS_STOP;
			endcase
			seq_o.comm_slice <= slice_r;
		end
	end

	// interrupt events
	always_comb begin
		ev = '0;
		ev[scs_pkg::IRQ_OVERRUN] = over && state_r != scs_pkg::SCS_STOP &&
			state_r != scs_pkg::SCS_STARTUP;
		ev[scs_pkg::IRQ_STOP] = ev[scs_pkg::IRQ_OVERRUN] &&
			(overrun_armed_r || (state_r != scs_pkg::SCS_PAD &&
			!ctrl_r[scs_pkg::CTRL_HANDLER_EN]));
		ev[scs_pkg::IRQ_CYC_DONE] = seq_o.cycle_start;
	end

	logic wr_go;
	assign wr_go = aw_ok_r && w_ok_r && !s_axi_bvalid;

	// axi write: address and data latched in any order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= scs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_r)
				scs_pkg::REG_CTRL, scs_pkg::REG_MAXCYC,
				scs_pkg::REG_MINCYC, scs_pkg::REG_COMM,
				scs_pkg::REG_IRQ_STAT, scs_pkg::REG_IRQ_MASK:
					s_axi_bresp <= scs_pkg::RESP_OKAY;
				scs_pkg::REG_STATUS, scs_pkg::REG_CYCTIME:
					s_axi_bresp <= scs_pkg::RESP_OKAY;
				default: s_axi_bresp <= scs_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_ok_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_ok_r && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// configuration; limits clamp out-of-range values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= '0;
			max_ms_r <= scs_pkg::MAX_CYC_DEF_MS;
			min_ms_r <= scs_pkg::MIN_CYC_LO_MS;
			comm_pct_r <= scs_pkg::COMM_PCT_DEF;
			imask_r <= '0;
		end else if (wr_go && wstrb_r[0]) begin
			case (awaddr_r)
			scs_pkg::REG_CTRL: ctrl_r <= wdata_r[1:0];
			scs_pkg::REG_MAXCYC: begin
				if (wdata_r[12:0] < scs_pkg::MAX_CYC_MIN_MS ||
						wdata_r[31:13] != '0)
					max_ms_r <= (wdata_r[31:13] != '0) ?
						scs_pkg::MAX_CYC_LIM_MS : scs_pkg::MAX_CYC_MIN_MS;
				else if (wdata_r[12:0] > scs_pkg::MAX_CYC_LIM_MS)
					max_ms_r <= scs_pkg::MAX_CYC_LIM_MS;
				else
					max_ms_r <= wdata_r[12:0];
			end
			scs_pkg::REG_MINCYC: begin
				if (wdata_r[12:0] < scs_pkg::MIN_CYC_LO_MS)
					min_ms_r <= scs_pkg::MIN_CYC_LO_MS;
				else if (wdata_r[12:0] > max_ms_r || wdata_r[31:13] != '0)
					min_ms_r <= max_ms_r;
				else
					min_ms_r <= wdata_r[12:0];
			end
			scs_pkg::REG_COMM: comm_pct_r <=
				(wdata_r[7:0] > scs_pkg::COMM_PCT_MAX) ?
				scs_pkg::COMM_PCT_MAX : wdata_r[7:0];
			scs_pkg::REG_IRQ_MASK: imask_r <= wdata_r[scs_pkg::IRQ_W-1:0];
			default: ;
			endcase
		end
	end

	// sticky status: hardware set beats write-one-to-clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ist_r <= '0;
		else if (wr_go && wstrb_r[0] && awaddr_r == scs_pkg::REG_IRQ_STAT)
			ist_r <= (ist_r & ~wdata_r[scs_pkg::IRQ_W-1:0]) | ev;
		else
			ist_r <= ist_r | ev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(ist_r & imask_r);
	end

	// axi read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= scs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid &&
				s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= scs_pkg::RESP_OKAY;
				case (s_axi_araddr)
				scs_pkg::REG_CTRL: s_axi_rdata <= {30'h0, ctrl_r};
				scs_pkg::REG_MAXCYC: s_axi_rdata <= {19'h0, max_ms_r};
				scs_pkg::REG_MINCYC: s_axi_rdata <= {19'h0, min_ms_r};
				scs_pkg::REG_COMM: s_axi_rdata <= {24'h0, comm_pct_r};
				scs_pkg::REG_STATUS: s_axi_rdata <= {16'h0,
					time_error_code, 1'b0, slice_r, overrun_armed_r,
					seq_o.run, 1'b0, 3'(state_r)};
				scs_pkg::REG_IRQ_STAT: s_axi_rdata <=
					{29'h0, ist_r};
				scs_pkg::REG_IRQ_MASK: s_axi_rdata <=
					{29'h0, imask_r};
				scs_pkg::REG_CYCTIME: s_axi_rdata <= {19'h0, cyc_ms_r};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= scs_pkg::RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// file: logic/scs_pkg.sv
package scs_pkg;
	// cycle timing
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int COMM_PERIOD_MS = 100;
	localparam int MIN_CYC_TOL_MS = 1;
	localparam logic [12:0] MAX_CYC_MIN_MS = 13'h0001;
	localparam logic [12:0] MAX_CYC_LIM_MS = 13'h1770;
	localparam logic [12:0] MAX_CYC_DEF_MS = 13'h0096;
	localparam logic [12:0] MIN_CYC_LO_MS = 13'h0001;
	localparam logic [7:0] COMM_PCT_DEF = 8'h0A;
	localparam logic [7:0] COMM_PCT_MAX = 8'h64;
	localparam logic [7:0] TERR_CODE_MAXCYC = 8'h01;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MAXCYC = 8'h04;
	localparam logic [7:0] REG_MINCYC = 8'h08;
	localparam logic [7:0] REG_COMM = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] REG_IRQ_MASK = 8'h18;
	localparam logic [7:0] REG_CYCTIME = 8'h1C;

	// control bit positions
	localparam int CTRL_HANDLER_EN = 0;
	localparam int CTRL_MINCYC_EN = 1;

	// interrupt status bit positions
	localparam int IRQ_OVERRUN = 0;
	localparam int IRQ_STOP = 1;
	localparam int IRQ_CYC_DONE = 2;
	localparam int IRQ_W = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SCS_STARTUP = 3'b000,
		SCS_WORK = 3'b001,
		SCS_PAD = 3'b011,
		SCS_COMM = 3'b010,
		SCS_HANDLER = 3'b110,
		SCS_STOP = 3'b100
	} scs_state_t;

	// sequencer handshake toward the program-execution engine
	typedef struct packed {
		logic startup_done;
		logic cycle_end;
		logic retrigger;
		logic in_handler;
		logic handler_done;
	} scs_seq_in_t;

	typedef struct packed {
		logic run;
		logic cycle_start;
		logic handler_go;
		logic pad_active;
		logic comm_slice;
		logic stopped;
	} scs_seq_out_t;
endpackage

// file: verif/scs_supervisor_asserts.sv
`timescale 1ns/1ps
module scs_supervisor_asserts (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus answers
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// sequencer
	input wire scs_pkg::scs_seq_in_t seq_i,
	input wire scs_pkg::scs_seq_out_t seq_o,
	input wire logic [7:0] time_error_code
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_run_after_boot: assert property ($rose(seq_o.run) |->
		$past(seq_i.startup_done) && seq_o.cycle_start) else $error("early run");
	chk_stop_sticky: assert property (seq_o.stopped |=>
		seq_o.stopped && !seq_o.run) else $error("stop left");
	chk_stop_no_go: assert property ($rose(seq_o.stopped) |->
		!seq_o.run && !seq_o.handler_go) else $error("stop with run");
	chk_go_pulse: assert property (seq_o.handler_go |=>
		!seq_o.handler_go && !seq_o.stopped) else $error("handler pulse");
	chk_go_code: assert property (seq_o.handler_go |=>
		time_error_code == scs_pkg::TERR_CODE_MAXCYC) else $error("bad code");
	chk_pad_exit: assert property ($fell(seq_o.pad_active) && seq_o.run
		|-> seq_o.cycle_start) else $error("pad exit");
	chk_pad_hold: assert property (seq_o.pad_active |->
		!seq_o.cycle_start) else $error("start in pad");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("late read");
	chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	cover property (seq_o.handler_go);
	cover property ($rose(seq_o.stopped));
	cover property ($rose(seq_o.pad_active));
endmodule

bind scs_supervisor scs_supervisor_asserts u_chk (.*);

// file: verif/scs_supervisor_tb.sv
`timescale 1ns/1ps
module scs_supervisor_tb;
	logic aclk, aresetn, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr, time_error_code;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	scs_pkg::scs_seq_in_t seq_i;
	scs_pkg::scs_seq_out_t seq_o;
	int miscompares, samples_checked, t, go;
	logic p;
	// 10 clocks per ms keeps long cycle limits short in simulation
	scs_supervisor #(.TICK_CYC(10)) uut (.*);
	initial begin
		aclk = 0;
		forever #20 aclk = ~aclk;
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit da, dw;
		da = 0;
		dw = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(da && dw)) begin
			@(posedge aclk);
			if (!da && s_axi_awready) begin
				da = 1;
				s_axi_awvalid <= 0;
			end
			if (!dw && s_axi_wready) begin
				dw = 1;
				s_axi_wvalid <= 0;
			end
		end
		s_axi_bready <= 1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// ends a cycle after n clocks; t counts clocks until the next start
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
		seq_i.cycle_end <= 1;
		@(posedge aclk);
		seq_i.cycle_end <= 0;
		#1;
		p = seq_o.pad_active;
		t = 0;
		while (seq_o.cycle_start !== 1'b1 && t < 200) begin
			@(posedge aclk);
			#1;
			t++;
		end
	endtask
	task automatic boot;
		@(posedge aclk);
		seq_i.startup_done <= 1;
		@(posedge aclk);
		seq_i.startup_done <= 0;
		#1;
		cmp(seq_o.run, 1);
		cmp(seq_o.cycle_start, 1);
	endtask
	task automatic t_regs;
		rd(8'h04);
		cmp(rd_v, 32'h0000_0096);
		rd(8'h00);
		cmp(rd_v, 32'h0000_0000);
		rd(8'h40);
		cmp(rsp, 2'h2);
		wr(8'h40, 32'h0000_0001);
		cmp(rsp, 2'h2);
		wr(8'h04, 32'h0000_1b58);
		rd(8'h04);
		cmp(rd_v, 32'h0000_1770);
		wr(8'h04, 32'h0000_0000);
		rd(8'h04);
		cmp(rd_v, 32'h0000_0001);
		wr(8'h04, 32'h0000_0008);
		wr(8'h08, 32'h0000_0009);
		rd(8'h08);
		cmp(rd_v, 32'h0000_0008);
		wr(8'h08, 32'h0000_0003);
		cmp(seq_o.run, 0);
	endtask
	task automatic t_min;
		cyc(5);
		cmp(t, 0);
		wr(8'h00, 32'h0000_0002);
		cyc(1);
		cyc(2);
		cmp(p, 1);
		cmp(t + 3 >= 20 && t + 3 <= 40, 1);
		cyc(50);
		cmp(t, 0);
		cmp(p, 0);
		cmp(seq_o.stopped, 0);
		wr(8'h00, 32'h0000_0000);
		cyc(1);
	endtask
	// endless retriggered cycle: slice must still show up
	task automatic t_slice;
		int hi;
		hi = 0;
		go = 0;
		for (int k = 0; k < 1000; k++) begin
			@(posedge aclk);
			seq_i.retrigger <= (k % 40 == 0);
			hi += (seq_o.comm_slice === 1'b1);
			go += (seq_o.handler_go === 1'b1) + (seq_o.stopped === 1'b1);
		end
		cmp(hi >= 90 && hi <= 110, 1);
		cmp(go, 0);
		cyc(1);
	endtask
	task automatic t_handler;
		wr(8'h00, 32'h0000_0001);
		cyc(1);
		t = 0;
		while (seq_o.handler_go !== 1'b1 && t < 300) begin
			@(posedge aclk);
			#1;
			t++;
		end
		cmp(t >= 70 && t <= 91, 1);
		@(posedge aclk);
		seq_i.in_handler <= 1;
		#1;
		cmp(time_error_code, 8'h01);
		cmp(seq_o.stopped, 0);
		@(posedge aclk);
		seq_i.retrigger <= 1;
		@(posedge aclk);
		seq_i.retrigger <= 0;
		go = 0;
		t = 0;
		while (seq_o.stopped !== 1'b1 && t < 200) begin
			@(posedge aclk);
			go += (seq_o.handler_go === 1'b1);
			t++;
		end
		cmp(go, 0);
		cmp(seq_o.stopped, 1);
		seq_i.in_handler <= 0;
	endtask
	task automatic t_stop;
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		wr(8'h04, 32'h0000_0002);
		boot;
		repeat (40) @(posedge aclk);
		#1;
		cmp(seq_o.stopped, 1);
		cmp(seq_o.run, 0);
		rd(8'h14);
		cmp(rd_v[1], 1);
		wr(8'h18, 32'h0000_0007);
		repeat (2) @(posedge aclk);
		p = irq;
		wr(8'h18, 32'h0000_0000);
		repeat (2) @(posedge aclk);
		cmp(p, 1);
		cmp(irq, 0);
		wr(8'h14, 32'h0000_0000);
		rd(8'h14);
		cmp(rd_v[1], 1);
		wr(8'h14, 32'h0000_0007);
		rd(8'h14);
		cmp(rd_v[2:0], 3'h0);
		wr(8'h18, 32'h0000_0007);
		repeat (2) @(posedge aclk);
		cmp(irq, 0);
	endtask
	initial begin
		#800000;
		miscompares++;
		stop_test;
	end
	initial begin
		aresetn = 0;
		seq_i = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		t_regs;
		boot;
		t_min;
		t_slice;
		t_handler;
		t_stop;
		stop_test;
	end
endmodule
